// ### rtl/aosm_top.sv
// per-channel output control and health monitor for the angle output card
//
// Contract
// - software selects synchro, differential or single-ended type
// - legs unused by selected type held off
// - 90V variant forces differential resolver, S4 on
// - leg status true only when used and unfaulted
// - leg recovers automatically when fault clears
// - per-channel software transformation ratio selection
// - self test records per-channel pass or fail
// - reference frequency measured and reported in hertz
// - reference-loss flag set below threshold
// - threshold chosen from selected configuration
// - reference-loss flag follows live condition
// - converter over-current latches shutdown of all channels
// - each converter active status readable
// - channel to converter map by channel count
`timescale 1ns/1ps
module aosm_top
  import aosm_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = aosm_pkg::GATE_CYC  // frequency gate length
) (
  input  wire logic                               core_clk,          // 200 MHz clock
  input  wire logic                               rst_n,             // async reset
  input  wire logic                               clk_en,            // freezes state when low
  input  wire logic                               variant_90v,       // 90V build strap
  input  wire logic                               six_channel,       // 6-channel build strap
  input  wire logic [aosm_pkg::NUM_CH*2-1:0]      sig_type_sel,      // 2 bits per channel
  input  wire logic [aosm_pkg::NUM_CH*3-1:0]      transformation_ratio, // 3 bits per ch
  input  wire logic                               config_load,       // latch type and ratio
  input  wire logic [aosm_pkg::NUM_CH*4-1:0]      leg_fault,         // async leg faults
  input  wire logic [aosm_pkg::NUM_CH-1:0]        ref_low_cmp,       // async: ref below thr
  input  wire logic [aosm_pkg::NUM_CH-1:0]        ref_zero_cross,    // async carrier squarewave
  input  wire logic [1:0]                         conv_overcurrent,  // async, A=0 B=1
  input  wire logic [1:0]                         conv_power_good,   // async, A=0 B=1
  input  wire logic                               self_test_start,   // one-cycle pulse
  input  wire logic [aosm_pkg::NUM_CH-1:0]        self_test_cmp_ok,  // channel output ok
  output logic      [aosm_pkg::NUM_CH*4-1:0]      leg_enable,        // leg drive enables
  output logic      [aosm_pkg::NUM_CH*4-1:0]      leg_active,        // leg status bits
  output logic      [aosm_pkg::NUM_CH*3-1:0]      ratio_out,         // active ratio per ch
  output logic      [aosm_pkg::NUM_CH*2-1:0]      ref_thr_sel,       // threshold per ch
  output logic      [aosm_pkg::NUM_CH-1:0]        reference_loss,    // live loss flags
  output logic      [aosm_pkg::NUM_CH*16-1:0]     ref_freq_hz,       // Hz per channel
  output logic      [1:0]                         conv_active,       // converter status
  output logic                                    shutdown,          // latched shutdown
  output logic                                    self_test_ref_en,  // internal DC ref on
  output logic                                    self_test_busy,    // test running
  output logic      [aosm_pkg::NUM_CH-1:0]        self_test_pass     // per-channel result
);
  import aosm_pkg::*;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // legs used by a signal type, index by leg position
  function automatic logic [NUM_LEG-1:0] legs_used(input logic [1:0] t);
    logic [NUM_LEG-1:0] m;
    m = '0;
    unique case (t)
      SIG_SYNCHRO:  m = 4'h7;    // S1..S3
      SIG_DIFF_RES: m = 4'hF;    // S1..S4
      SIG_SE_RES:   m = 4'h6;    // S2,S3 only
      default:      m = 4'h0;    // illegal code drives nothing
    endcase
    return m;
  endfunction : legs_used

  // converter feeding a channel: 0 = A, 1 = B
  function automatic logic conv_of(input int unsigned ch, input logic six);
    return six ? (ch >= SPLIT_6CH) : (ch >= SPLIT_4CH);
  endfunction : conv_of

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned SYN_W = NUM_CH*4 + NUM_CH*3 + 4;
  logic [SYN_W-1:0] syn_out;
  logic [NUM_CH*4-1:0] fault_s;
  logic [NUM_CH-1:0]   low_s;
  logic [NUM_CH-1:0]   zc_s;
  logic [NUM_CH-1:0]   stok_s;
  logic [1:0]          oc_s;
  logic [1:0]          pg_s;

  aosm_sync #(.W(SYN_W)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in ({conv_power_good, conv_overcurrent, self_test_cmp_ok,
                ref_zero_cross, ref_low_cmp, leg_fault}),
    .sync_out (syn_out)
  );
  assign fault_s = syn_out[NUM_CH*4-1:0];
  assign low_s   = syn_out[NUM_CH*5-1:NUM_CH*4];
  assign zc_s    = syn_out[NUM_CH*6-1:NUM_CH*5];
  assign stok_s  = syn_out[NUM_CH*7-1:NUM_CH*6];
  assign oc_s    = syn_out[NUM_CH*7+1:NUM_CH*7];
  assign pg_s    = syn_out[NUM_CH*7+3:NUM_CH*7+2];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [NUM_CH*2-1:0] type_q;

  // type and ratio latched on load; 90V build overrides type
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      type_q    <= {NUM_CH{SIG_RESET}};
      ratio_out <= {NUM_CH{TR_RESET}};
    end else if (clk_en) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (variant_90v) begin
          type_q[c*2 +: 2]    <= SIG_DIFF_RES;
          ratio_out[c*3 +: 3] <= TR_0P7826;
        end else if (config_load) begin
          type_q[c*2 +: 2]    <= sig_type_sel[c*2 +: 2];
          ratio_out[c*3 +: 3] <= transformation_ratio[c*3 +: 3];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // converter shutdown and status
  // ----------------------------------------------------------------
  // only reset (power cycle) clears the latch; no software path
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown <= 1'b0;
    end else if (clk_en && (|oc_s)) begin
      shutdown <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_active <= 2'h0;
    end else if (clk_en) begin
      conv_active <= pg_s & ~oc_s & {2{~shutdown}};
    end
  end

  // ----------------------------------------------------------------
  // leg enables, status and thresholds
  // ----------------------------------------------------------------
  // status recomputed each cycle, so a cleared fault restores the leg
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      leg_enable  <= '0;
      leg_active  <= '0;
      ref_thr_sel <= '0;
    end else if (clk_en) begin
      for (int c = 0; c < NUM_CH; c++) begin
        logic [NUM_LEG-1:0] use_m;
        logic               pwr;
        use_m = legs_used(type_q[c*2 +: 2]);
        pwr   = ~shutdown & conv_active[conv_of(c, six_channel)];
        leg_enable[c*4 +: 4] <= use_m & {NUM_LEG{~shutdown}};
        leg_active[c*4 +: 4] <= use_m & ~fault_s[c*4 +: 4]
                                & {NUM_LEG{pwr}};
        if (variant_90v) begin
          ref_thr_sel[c*2 +: 2] <= THR_16P9_VPK;
        end else if (ratio_out[c*3 +: 3] == TR_1 || ratio_out[c*3 +: 3] == TR_2) begin
          ref_thr_sel[c*2 +: 2] <= THR_1_VPK;
        end else begin
          ref_thr_sel[c*2 +: 2] <= THR_3P8_VPK;
        end
      end
    end
  end

  // live reference-loss flag, no latching
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reference_loss <= '0;
    end else if (clk_en) begin
      reference_loss <= low_s;
    end
  end

  // ----------------------------------------------------------------
  // reference frequency counters
  // ----------------------------------------------------------------
  // rising edges counted over a 1 s gate give hertz exactly; a DC
  // reference reads zero; reference_loss is set from ref_low_cmp only
  logic [GATE_W-1:0]        gate_cnt;
  logic [NUM_CH-1:0]        zc_d;
  logic [NUM_CH*FREQ_W-1:0] edge_cnt;
  logic                     gate_end;
  assign gate_end = (gate_cnt == GATE_W'(GATE_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_cnt <= '0;
    end else if (clk_en) begin
      gate_cnt <= gate_end ? '0 : gate_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      zc_d        <= '0;
      edge_cnt    <= '0;
      ref_freq_hz <= '0;
    end else if (clk_en) begin
      zc_d <= zc_s;
      for (int c = 0; c < NUM_CH; c++) begin
        logic [FREQ_W-1:0] nxt;
        nxt = edge_cnt[c*FREQ_W +: FREQ_W];
        if (zc_s[c] && !zc_d[c] && nxt != {FREQ_W{1'b1}}) begin
          nxt = nxt + 1'b1;
        end
        if (gate_end) begin
          ref_freq_hz[c*FREQ_W +: FREQ_W] <= nxt;
          edge_cnt[c*FREQ_W +: FREQ_W]    <= '0;
        end else begin
          edge_cnt[c*FREQ_W +: FREQ_W]    <= nxt;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // self test sequencer
  // ----------------------------------------------------------------
  aosm_st_e        st;
  logic [ST_W-1:0] st_cnt;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st               <= AOSM_ST_IDLE;
      st_cnt           <= '0;
      self_test_ref_en <= 1'b0;
      self_test_busy   <= 1'b0;
      self_test_pass   <= '0;
    end else if (clk_en) begin
      unique case (st)
        AOSM_ST_IDLE: begin
          if (self_test_start) begin
            st               <= AOSM_ST_SETTLE;
            st_cnt           <= '0;
            self_test_ref_en <= 1'b1;
            self_test_busy   <= 1'b1;
          end
        end
        AOSM_ST_SETTLE: begin
          // let channel outputs settle on the DC reference before judging
          if (st_cnt == ST_W'(ST_SETTLE_CYC - 1)) begin
            st             <= AOSM_ST_DONE;
            self_test_pass <= stok_s;
          end else begin
            st_cnt <= st_cnt + 1'b1;
          end
        end
        AOSM_ST_DONE: begin
          st               <= AOSM_ST_IDLE;
          self_test_ref_en <= 1'b0;
          self_test_busy   <= 1'b0;
        end
      endcase
    end
  end
endmodule : aosm_top

// ### rtl/aosm_pkg.sv
// package of constants and types for the angle output status monitor
package aosm_pkg;
  localparam int unsigned NUM_CH        = 6;
  localparam int unsigned NUM_LEG       = 4;
  localparam int unsigned CH_W          = 3;
  // leg positions inside a channel's leg vector
  localparam int unsigned LEG_S1        = 0;
  localparam int unsigned LEG_S2        = 1;
  localparam int unsigned LEG_S3        = 2;
  localparam int unsigned LEG_S4        = 3;
  // signal type codes
  localparam logic [1:0]  SIG_SYNCHRO   = 2'h0;
  localparam logic [1:0]  SIG_DIFF_RES  = 2'h1;
  localparam logic [1:0]  SIG_SE_RES    = 2'h2;
  localparam logic [1:0]  SIG_RESET     = 2'h1;
  // transformation_ratio codes
  localparam logic [2:0]  TR_0P4538     = 3'h0;
  localparam logic [2:0]  TR_0P2615     = 3'h1;
  localparam logic [2:0]  TR_1          = 3'h2;
  localparam logic [2:0]  TR_2          = 3'h3;
  localparam logic [2:0]  TR_0P7826     = 3'h4;
  localparam logic [2:0]  TR_RESET      = 3'h0;
  // reference-loss threshold selector codes
  localparam logic [1:0]  THR_3P8_VPK   = 2'h0;
  localparam logic [1:0]  THR_1_VPK     = 2'h1;
  localparam logic [1:0]  THR_16P9_VPK  = 2'h2;
  // frequency measurement: 1 s gate at 200 MHz gives Hz directly
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned GATE_MS       = 1000;
  localparam int unsigned GATE_CYC      = CLK_HZ / 1000 * GATE_MS;
  localparam int unsigned FREQ_W        = 16;
  localparam int unsigned GATE_W        = 28;
  // self test settle time per run
  localparam int unsigned ST_SETTLE_US  = 100;
  localparam int unsigned ST_SETTLE_CYC = CLK_HZ / 1_000_000 * ST_SETTLE_US;
  localparam int unsigned ST_W          = 16;
  // converter split by channel count
  localparam int unsigned SPLIT_4CH     = 2;
  localparam int unsigned SPLIT_6CH     = 3;

  typedef enum logic [2:0] {
    AOSM_ST_IDLE   = 3'b001,
    AOSM_ST_SETTLE = 3'b010,
    AOSM_ST_DONE   = 3'b100
  } aosm_st_e;
endpackage : aosm_pkg

// ### rtl/aosm_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module aosm_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk,  // system clock
  input  wire logic         rst_n,     // async reset, active low
  input  wire logic         clk_en,    // clock enable
  input  wire logic [W-1:0] async_in,  // raw levels
  output logic      [W-1:0] sync_out   // synchronised levels
);
  logic [W-1:0] meta;

  // first stage read only by second stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : aosm_sync

// ### testbench/aosm_top_sva.sv
// port-level checker of the angle output status monitor
`timescale 1ns/1ps
module aosm_top_sva
  import aosm_pkg::*;
(
  input wire logic                     core_clk,         // system clock
  input wire logic                     rst_n,            // async reset
  input wire logic                     variant_90v,      // 90V strap
  input wire logic [NUM_CH-1:0]        ref_low_cmp,      // raw loss comparators
  input wire logic [1:0]               conv_overcurrent, // raw converter faults
  input wire logic [1:0]               conv_power_good,  // raw converter health
  input wire logic                     self_test_start,  // self test pulse
  input wire logic [NUM_CH*4-1:0]      leg_enable,       // leg drive enables
  input wire logic [NUM_CH-1:0]        reference_loss,   // loss flags
  input wire logic [1:0]               conv_active,      // converter status
  input wire logic                     shutdown,         // latched shutdown
  input wire logic                     self_test_ref_en, // DC ref on
  input wire logic                     self_test_busy    // test running
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // --------------------------------------------------------------------------
  // leg patterns
  // --------------------------------------------------------------------------
  // only the four per-type masks may ever appear on a channel
  logic pat_ok;
  always_comb begin
    pat_ok = 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      pat_ok &= leg_enable[c*4 +: 4] inside {4'h0, 4'h6, 4'h7, 4'hF};
    end
  end
  a_leg_pattern_legal: assert property (pat_ok)
    else $error("leg enable pattern not a legal type mask");
  a_fixed_diff_90v: assert property (
    variant_90v && $past(variant_90v, 3) && $past(rst_n, 3)
    && !shutdown && !$past(shutdown) |-> leg_enable == '1)
    else $error("90V build not fixed to differential legs");
  // --------------------------------------------------------------------------
  // live status paths, three cycles through the synchroniser
  // --------------------------------------------------------------------------
  a_loss_follows_cmp: assert property ($past(rst_n, 3)
    |-> reference_loss == $past(ref_low_cmp, 3))
    else $error("reference loss does not follow comparator");
  a_conv_status_live: assert property ($past(rst_n, 3) && !shutdown
    |-> conv_active == ($past(conv_power_good, 3) & ~$past(conv_overcurrent, 3)))
    else $error("converter status wrong");
  // --------------------------------------------------------------------------
  // shutdown
  // --------------------------------------------------------------------------
  a_oc_sets_shutdown: assert property (|conv_overcurrent |-> ##[1:4] shutdown)
    else $error("overcurrent did not shut down");
  a_shutdown_stays: assert property (shutdown |=> shutdown)
    else $error("shutdown released without reset");
  a_shutdown_legs_off: assert property (
    shutdown |=> leg_enable == '0 && conv_active == 2'h0)
    else $error("outputs still on during shutdown");
  // --------------------------------------------------------------------------
  // self test handshake
  // --------------------------------------------------------------------------
  a_ref_with_busy: assert property (self_test_ref_en == self_test_busy)
    else $error("DC ref enable differs from busy");
  a_start_takes: assert property (
    self_test_start && !self_test_busy && !$past(self_test_busy) |=> self_test_busy)
    else $error("idle start not taken");
endmodule : aosm_top_sva

bind aosm_top aosm_top_sva i_aosm_top_sva (.core_clk(core_clk), .rst_n(rst_n),
  .variant_90v(variant_90v), .ref_low_cmp(ref_low_cmp), .conv_overcurrent(conv_overcurrent),
  .conv_power_good(conv_power_good), .self_test_start(self_test_start),
  .leg_enable(leg_enable), .reference_loss(reference_loss), .conv_active(conv_active),
  .shutdown(shutdown), .self_test_ref_en(self_test_ref_en), .self_test_busy(self_test_busy));

// ### testbench/aosm_receiver_model.sv
// behavioural receivers and reference sources at the channel outputs
`timescale 1ns/1ps
module aosm_receiver_model
  import aosm_pkg::*;
(
  input  wire logic                core_clk,         // system clock
  input  wire logic [NUM_CH*4-1:0] leg_enable,       // legs driven by the card
  input  wire logic                self_test_ref_en, // DC ref applied
  input  wire logic [NUM_CH-1:0]   bad_ch,           // receivers that see a broken output
  input  wire logic [7:0]          half_per,         // base carrier half period, cycles
  output logic      [NUM_CH-1:0]   ref_zero_cross,   // carrier square waves
  output logic      [NUM_CH-1:0]   self_test_cmp_ok  // output judged healthy
);
  logic [7:0] cnt [NUM_CH];
  // carrier of channel c has half period half_per + c, so channels differ
  initial begin
    ref_zero_cross = '0;
    for (int c = 0; c < NUM_CH; c++) cnt[c] = 8'h00;
  end
  always @(posedge core_clk) begin
    #1;
    for (int c = 0; c < NUM_CH; c++) begin
      cnt[c] = cnt[c] + 8'h01;
      if (cnt[c] >= half_per + 8'(c)) begin
        cnt[c] = 8'h00;
        ref_zero_cross[c] = ~ref_zero_cross[c];
      end
    end
  end
  // no drive on the legs means no healthy reading, whatever the ref
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      self_test_cmp_ok[c] = self_test_ref_en & (|leg_enable[c*4 +: 4]) & ~bad_ch[c];
    end
  end
endmodule : aosm_receiver_model

// ### testbench/angle_output_status_monitor_bench.sv
// self-checking bench of the angle output status monitor
`timescale 1ns/1ps
module angle_output_status_monitor_bench;
  import aosm_pkg::*;
  localparam int unsigned GATE = 1000; // short gate, counts are edges per gate
  logic core_clk, rst_n, v90, six, cfg, st_start, shut;
  logic [11:0] ty, thr;
  logic [17:0] tr, rat;
  logic [23:0] fault, en, act, en_exp;
  logic [5:0]  rlow, zc, cmp_ok, loss, pass, bad;
  logic [1:0]  oc, pg, cact;
  logic [95:0] freq;
  logic        ref_en, busy;
  int          n_mismatch = 0;
  int          n_checks = 0;

  aosm_top #(.GATE_CYCLES(GATE)) i_aosm_top (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
    .variant_90v(v90), .six_channel(six), .sig_type_sel(ty), .transformation_ratio(tr),
    .config_load(cfg), .leg_fault(fault), .ref_low_cmp(rlow), .ref_zero_cross(zc),
    .conv_overcurrent(oc), .conv_power_good(pg), .self_test_start(st_start),
    .self_test_cmp_ok(cmp_ok), .leg_enable(en), .leg_active(act), .ratio_out(rat),
    .ref_thr_sel(thr), .reference_loss(loss), .ref_freq_hz(freq), .conv_active(cact),
    .shutdown(shut), .self_test_ref_en(ref_en), .self_test_busy(busy), .self_test_pass(pass));
  aosm_receiver_model i_aosm_receiver_model (.core_clk(core_clk), .leg_enable(en),
    .self_test_ref_en(ref_en), .bad_ch(bad), .half_per(8'h05), .ref_zero_cross(zc),
    .self_test_cmp_ok(cmp_ok));

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [23:0] exp_en(input logic [11:0] t);
    for (int c = 0; c < 6; c++) begin
      case (t[c*2 +: 2])
        SIG_SYNCHRO:  exp_en[c*4 +: 4] = 4'h7;
        SIG_DIFF_RES: exp_en[c*4 +: 4] = 4'hF;
        SIG_SE_RES:   exp_en[c*4 +: 4] = 4'h6;
        default:      exp_en[c*4 +: 4] = 4'h0;
      endcase
    end
  endfunction : exp_en
  // ratios TR_1 and TR_2 belong to the 6.8 Vrms reference configurations
  function automatic logic [11:0] exp_thr(input logic [17:0] r);
    for (int c = 0; c < 6; c++) begin
      exp_thr[c*2 +: 2] = (r[c*3 +: 3] inside {TR_1, TR_2}) ? THR_1_VPK : THR_3P8_VPK;
    end
  endfunction : exp_thr
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // frequency reading allows five percent plus one count of gate phase
  task automatic chk_near(input logic [15:0] got, input int exp);
    n_checks++;
    if ((got >= exp - exp / 20 - 1 && got <= exp + exp / 20 + 1) !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_near
  task automatic load(input logic [11:0] t, input logic [17:0] r);
    ty = t;
    tr = r;
    cfg = 1'b1;
    tick(1);
    cfg = 1'b0;
    tick(3);
  endtask : load
  task automatic do_reset();
    rst_n = 1'b0;
    tick(16);
    rst_n = 1'b1;
    tick(4);
  endtask : do_reset
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // --------------------------------------------------------------------------
  // clock and watchdog
  // --------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #(5 * 60000);
    n_mismatch++;
    end_sim();
  end

  // --------------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------------
  initial begin
    logic [17:0] r;
    logic [11:0] t;
    {rst_n, v90, cfg, st_start, fault, rlow, oc, bad} = '0;
    {six, pg, ty, tr} = {1'b1, 2'h3, 12'h0, 18'h0};
    void'($urandom(32'hfc8f1760));
    do_reset();
    chk(rat, {6{TR_RESET}});
    chk(en, 24'hFFFFFF);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      for (int c = 0; c < 6; c++) begin
        t[c*2 +: 2] = (i == 0) ? 2'(c % 4) : 2'($urandom);
        r[c*3 +: 3] = (i == 0) ? 3'(c % 5) : 3'($urandom_range(0, 4));
      end
      load(t, r);
      chk(en, exp_en(t));
      chk(rat, r);
      chk(thr, exp_thr(r));
    end
    en_exp = exp_en(t);
    $display("test config done");
    fault = 24'($urandom);
    tick(4);
    chk(act, en_exp & ~fault);
    fault = '0;
    tick(4);
    chk(act, en_exp);
    for (int i = 0; i < 3; i++) begin
      rlow = 6'($urandom);
      tick(4);
      chk(loss, rlow);
    end
    $display("test status done");
    tick(3 * GATE);
    for (int c = 0; c < 6; c++) chk_near(freq[c*16 +: 16], GATE / (2 * (5 + c)));
    $display("test frequency done");
    load({6{SIG_DIFF_RES}}, '0);
    bad = 6'($urandom);
    st_start = 1'b1;
    tick(1);
    st_start = 1'b0;
    tick(1);
    chk(ref_en, 1'b1);
    for (int i = 0; i < 25000 && busy !== 1'b0; i++) tick(1);
    tick(2);
    chk(busy, 1'b0);
    chk(pass, 6'(~bad));
    $display("test self test done");
    pg = 2'h1;
    tick(4);
    chk(cact, 2'h1);
    chk(act, 24'h000FFF);
    six = 1'b0;
    tick(4);
    chk(act & 24'h00FFFF, 24'h0000FF);
    pg = 2'h2;
    tick(4);
    chk(act & 24'h00FFFF, 24'h00FF00);
    {six, pg} = 3'h7;
    $display("test converter map done");
    oc = 2'h2;
    tick(3);
    oc = 2'h0;
    load({6{SIG_DIFF_RES}}, '0);
    tick(4);
    chk({shut, cact, en}, {1'b1, 26'h0});
    $display("test shutdown done");
    v90 = 1'b1;
    do_reset();
    load({6{SIG_SYNCHRO}}, {6{TR_1}});
    chk({shut, en}, {1'b0, 24'hFFFFFF});
    chk(rat, {6{TR_0P7826}});
    chk(thr, {6{THR_16P9_VPK}});
    $display("test 90V done");
    end_sim();
  end
endmodule : angle_output_status_monitor_bench
